// file: tcc_compare_channels.sv
// timer with three equality compare channels, shadow registers and state-bit switching logic
`timescale 1ns/1ps

// Operation
// - each channel flags a match whenever counter equals its active compare value
// - software writes shadow; copy to active only on the shadow-transfer pulse
// - state bit follows direction, run, zero match, channel match and mode field
// - software set and reset bits force each state bit to one or zero; reset wins over set, the hysteresis hold overrides both
// - position inputs matter only in hysteresis mode, ignored in normal compare
// - match counting up gives up event, counting down gives down event
// - compare events do not depend on the current state bit
// - compare switching changes state bits only while the run bit is one
// - tick after a match while counting up sets the state bit
// - tick after zero match with parallel compare match counting up sets it
// - tick after a match while counting down clears the state bit
// - tick after zero match without compare match counting up clears it
// - compare value zero keeps the bit at one for full duty
// - compare value period plus one keeps the bit cleared for zero duty
// - mode 1001 is hysteresis mode; low position input clears the state bit
// - hysteresis mode holds the bit at zero while position input is zero
// - position inputs are sampled on the module clock, not the timer tick
// - hysteresis mode with position high lets normal switching act
// - shadow-transfer pulse only while its enable is set; enable has set/clear bits
// - zero match at counter 0000, one match at counter 0001
// - edge-aligned counts up only; center-aligned counts up and down, 1 is down
module tcc_compare_channels
  import tcc_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 arst_n,
  input  wire logic [TCC_AW-1:0]    bus_addr,
  input  wire logic [TCC_DW-1:0]    bus_wdata,
  input  wire logic                 bus_wr,
  input  wire logic                 bus_rd,
  output logic      [TCC_DW-1:0]    bus_rdata,
  input  wire logic [TCC_NCH-1:0]   position_input,
  output logic      [TCC_NCH-1:0]   channel_state_bit,
  output logic      [TCC_NCH-1:0]   channel_match,
  output logic      [TCC_NCH-1:0]   upcount_match_event,
  output logic      [TCC_NCH-1:0]   downcount_match_event,
  output logic                      zero_match,
  output logic                      one_match,
  output logic                      shadow_transfer_pulse,
  output logic                      timer_tick,
  output logic                      count_direction,
  output logic                      timer_run_bit
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic                   align_reg;
  logic [2:0]             div_reg;
  logic                   run_reg;
  logic                   ste_reg;
  logic                   dir_reg;
  logic [6:0]             pre_reg;
  logic [6:0]             pre_mask;
  logic [TCC_CW-1:0]      cnt_reg;
  logic [TCC_CW-1:0]      period_reg;
  logic [TCC_CW-1:0]      period_shd_reg;
  logic [TCC_NCH*TCC_MODE_W-1:0] channel_mode_register;
  logic [TCC_NCH-1:0]     pos_meta_reg;
  logic [TCC_NCH-1:0]     pos_sync_reg;
  logic [TCC_NCH-1:0][TCC_CW-1:0] active_compare_value;
  logic [TCC_NCH-1:0][TCC_CW-1:0] shadow_compare_value;
  logic [TCC_NCH-1:0]     state_reg;
  logic [TCC_NCH-1:0]     up_ev_reg;
  logic [TCC_NCH-1:0]     dn_ev_reg;
  logic [TCC_NCH-1:0]     state_set_bit;
  logic [TCC_NCH-1:0]     state_reset_bit;
  logic [TCC_DW-1:0]      rdata_reg;
  logic [TCC_DW-1:0]      rdata_next;
  logic                   tick;
  logic                   period_match;
  logic                   st_pulse;
  tcc_cmd_t               cmd;
  tcc_status_t            compare_state_register;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  // command and modify bits act only in the write cycle, they hold no state
  always_comb begin
    cmd = '0;
    if (bus_wr && bus_addr == TCC_OFF_CMD) begin
      cmd.run_set = bus_wdata[TCC_CMD_RUN_SET];
      cmd.run_clr = bus_wdata[TCC_CMD_RUN_CLR];
      cmd.ste_set = bus_wdata[TCC_CMD_STE_SET];
      cmd.ste_clr = bus_wdata[TCC_CMD_STE_CLR];
      cmd.cnt_rst = bus_wdata[TCC_CMD_CNT_RST];
    end
  end

  always_comb begin
    state_set_bit   = '0;
    state_reset_bit = '0;
    if (bus_wr && bus_addr == TCC_OFF_MODIFY) begin
      state_set_bit   = bus_wdata[TCC_MOD_SET_LO +: TCC_NCH];
      state_reset_bit = bus_wdata[TCC_MOD_RST_LO +: TCC_NCH];
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      align_reg <= 1'b0;
      div_reg   <= 3'h0;
    end else if (bus_wr && bus_addr == TCC_OFF_CTRL) begin
      align_reg <= bus_wdata[TCC_CTRL_ALIGN];
      div_reg   <= bus_wdata[TCC_CTRL_DIV_LO +: 3];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      channel_mode_register <= '0;
    end else if (bus_wr && bus_addr == TCC_OFF_MODE) begin
      channel_mode_register <= bus_wdata[TCC_NCH*TCC_MODE_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_reg <= 1'b0;
    end else if (cmd.run_clr) begin
      run_reg <= 1'b0;
    end else if (cmd.run_set) begin
      run_reg <= 1'b1;
    end
  end

  // enable drops after one transfer; a set in the same cycle as the transfer wins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ste_reg <= 1'b0;
    end else if (cmd.ste_set) begin
      ste_reg <= 1'b1;
    end else if (cmd.ste_clr || st_pulse) begin
      ste_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // prescaler and timer tick
  // ---------------------------------------------------------------
  // prescaler is held clear while stopped so the first tick is reproducible
  assign pre_mask = ~(TCC_PRE_ONES << div_reg);
  assign tick     = run_reg && ((pre_reg & pre_mask) == pre_mask);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_reg <= TCC_PRE_ZERO;
    end else if (!run_reg || tick) begin
      pre_reg <= TCC_PRE_ZERO;
    end else begin
      pre_reg <= pre_reg + 7'h01;
    end
  end

  // ---------------------------------------------------------------
  // counter and direction
  // ---------------------------------------------------------------
  assign zero_match   = (cnt_reg == TCC_CNT_ZERO);
  assign one_match    = (cnt_reg == TCC_CNT_ONE);
  assign period_match = (cnt_reg == period_reg);

  // direction changes one step late at the top, so the counter overshoots the period by one
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= TCC_CNT_ZERO;
      dir_reg <= 1'b0;
    end else if (cmd.cnt_rst) begin
      cnt_reg <= TCC_CNT_ZERO;
      dir_reg <= 1'b0;
    end else if (!run_reg && bus_wr && bus_addr == TCC_OFF_COUNT) begin
      cnt_reg <= bus_wdata[TCC_CW-1:0];
    end else if (tick) begin
      if (!align_reg) begin
        dir_reg <= 1'b0;
        cnt_reg <= period_match ? TCC_CNT_ZERO : cnt_reg + TCC_CNT_ONE;
      end else if (!dir_reg) begin
        cnt_reg <= cnt_reg + TCC_CNT_ONE;
        if (period_match) begin
          dir_reg <= 1'b1;
        end
      end else begin
        cnt_reg <= cnt_reg - TCC_CNT_ONE;
        if (one_match) begin
          dir_reg <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // shadow transfer
  // ---------------------------------------------------------------
  // transfer at the period match counting up, center aligned also at the one match counting down, or at once while the timer stands
  always_comb begin
    st_pulse = 1'b0;
    if (ste_reg) begin
      if (!run_reg) begin
        st_pulse = 1'b1;
      end else if (tick) begin
        st_pulse = (period_match && !dir_reg) || (align_reg && dir_reg && one_match);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      period_reg     <= TCC_CNT_ZERO;
      period_shd_reg <= TCC_CNT_ZERO;
    end else begin
      if (bus_wr && bus_addr == TCC_OFF_PERIOD) begin
        period_shd_reg <= bus_wdata[TCC_CW-1:0];
      end
      if (st_pulse) begin
        period_reg <= period_shd_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // position input synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_meta_reg <= '0;
      pos_sync_reg <= '0;
    end else begin
      pos_meta_reg <= position_input;
      pos_sync_reg <= pos_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // compare channels
  // ---------------------------------------------------------------
  for (genvar i = 0; i < TCC_NCH; i++) begin : g_ch
    localparam logic [7:0] CMP_OFF = TCC_OFF_CMP0 + 8'(TCC_CH_STRIDE * i);
    logic [3:0] channel_mode_field;
    logic       is_hyst;
    logic       is_cmp;
    logic       st_next;

    assign channel_mode_field = channel_mode_register[i*TCC_MODE_W +: TCC_MODE_W];
    assign is_hyst = (channel_mode_field == TCC_MODE_HYST);
    assign is_cmp  = is_hyst || channel_mode_field == TCC_MODE_CMP1 ||
                     channel_mode_field == TCC_MODE_CMP2 || channel_mode_field == TCC_MODE_CMP3;
    assign channel_match[i] = (cnt_reg == active_compare_value[i]);

    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        shadow_compare_value[i] <= TCC_CNT_ZERO;
        active_compare_value[i] <= TCC_CNT_ZERO;
      end else begin
        if (bus_wr && bus_addr == CMP_OFF) begin
          shadow_compare_value[i] <= bus_wdata[TCC_CW-1:0];
        end
        if (st_pulse) begin
          active_compare_value[i] <= shadow_compare_value[i];
        end
      end
    end

    // priority: position hold, then software modify, then switching rules
    always_comb begin
      st_next = state_reg[i];
      if (tick && is_cmp) begin
        if (!dir_reg) begin
          if (zero_match && channel_match[i]) begin
            st_next = 1'b1;
          end else if (zero_match) begin
            st_next = 1'b0;
          end else if (channel_match[i]) begin
            st_next = 1'b1;
          end
        end else if (channel_match[i]) begin
          st_next = 1'b0;
        end
      end
      if (state_set_bit[i]) begin
        st_next = 1'b1;
      end
      if (state_reset_bit[i]) begin
        st_next = 1'b0;
      end
      if (is_hyst && !pos_sync_reg[i]) begin
        st_next = 1'b0;
      end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        state_reg[i] <= 1'b0;
      end else begin
        state_reg[i] <= st_next;
      end
    end

    // events look at tick, mode, match and direction only, never at the state bit
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        up_ev_reg[i] <= 1'b0;
        dn_ev_reg[i] <= 1'b0;
      end else begin
        up_ev_reg[i] <= tick && is_cmp && channel_match[i] && !dir_reg;
        dn_ev_reg[i] <= tick && is_cmp && channel_match[i] && dir_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  assign compare_state_register = '{ste: ste_reg, dir: dir_reg, run: run_reg, state: state_reg};

  always_comb begin
    rdata_next = TCC_RD_ZERO;
    unique case (bus_addr)
      TCC_OFF_CTRL: begin
        rdata_next[TCC_CTRL_ALIGN]       = align_reg;
        rdata_next[TCC_CTRL_DIV_LO +: 3] = div_reg;
      end
      TCC_OFF_PERIOD: rdata_next[TCC_CW-1:0] = period_reg;
      TCC_OFF_CMP0:                          rdata_next[TCC_CW-1:0] = active_compare_value[0];
      TCC_OFF_CMP0 + TCC_CH_STRIDE:          rdata_next[TCC_CW-1:0] = active_compare_value[1];
      TCC_OFF_CMP0 + 8'(2 * TCC_CH_STRIDE):  rdata_next[TCC_CW-1:0] = active_compare_value[2];
      TCC_OFF_SHD0:                          rdata_next[TCC_CW-1:0] = shadow_compare_value[0];
      TCC_OFF_SHD0 + TCC_CH_STRIDE:          rdata_next[TCC_CW-1:0] = shadow_compare_value[1];
      TCC_OFF_SHD0 + 8'(2 * TCC_CH_STRIDE):  rdata_next[TCC_CW-1:0] = shadow_compare_value[2];
      TCC_OFF_MODE: rdata_next[TCC_NCH*TCC_MODE_W-1:0] = channel_mode_register;
      TCC_OFF_STATE: begin
        rdata_next[TCC_NCH-1:0]   = compare_state_register.state;
        rdata_next[TCC_STAT_RUN]  = compare_state_register.run;
        rdata_next[TCC_STAT_DIR]  = compare_state_register.dir;
        rdata_next[TCC_STAT_STE]  = compare_state_register.ste;
      end
      TCC_OFF_COUNT: rdata_next[TCC_CW-1:0] = cnt_reg;
      default: rdata_next = TCC_RD_ZERO;
    endcase
  end

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= TCC_RD_ZERO;
    end else begin
      rdata_reg <= bus_rd ? rdata_next : TCC_RD_ZERO;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign bus_rdata             = rdata_reg;
  assign channel_state_bit     = state_reg;
  assign upcount_match_event   = up_ev_reg;
  assign downcount_match_event = dn_ev_reg;
  assign shadow_transfer_pulse = st_pulse;
  assign timer_tick            = tick;
  assign count_direction       = dir_reg;
  assign timer_run_bit         = run_reg;

endmodule : tcc_compare_channels

// file: tcc_pkg.sv
// package with register map, field layout and mode codes of the timer compare channel block
package tcc_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int TCC_NCH = 3;
  localparam int TCC_CW  = 16;
  localparam int TCC_AW  = 8;
  localparam int TCC_DW  = 32;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] TCC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] TCC_OFF_CMD    = 8'h04;
  localparam logic [7:0] TCC_OFF_PERIOD = 8'h08;
  localparam logic [7:0] TCC_OFF_CMP0   = 8'h0c;
  localparam logic [7:0] TCC_OFF_SHD0   = 8'h18;
  localparam logic [7:0] TCC_OFF_MODE   = 8'h24;
  localparam logic [7:0] TCC_OFF_MODIFY = 8'h28;
  localparam logic [7:0] TCC_OFF_STATE  = 8'h2c;
  localparam logic [7:0] TCC_OFF_COUNT  = 8'h30;
  localparam logic [7:0] TCC_CH_STRIDE  = 8'h04;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int TCC_CTRL_ALIGN  = 0;
  localparam int TCC_CTRL_DIV_LO = 4;
  localparam int TCC_CMD_RUN_SET = 0;
  localparam int TCC_CMD_RUN_CLR = 1;
  localparam int TCC_CMD_STE_SET = 2;
  localparam int TCC_CMD_STE_CLR = 3;
  localparam int TCC_CMD_CNT_RST = 4;
  localparam int TCC_MOD_SET_LO  = 0;
  localparam int TCC_MOD_RST_LO  = 8;
  localparam int TCC_MODE_W      = 4;
  localparam int TCC_STAT_RUN    = 8;
  localparam int TCC_STAT_DIR    = 9;
  localparam int TCC_STAT_STE    = 10;

  // ---------------------------------------------------------------
  // values
  // ---------------------------------------------------------------
  localparam logic [15:0] TCC_CNT_ZERO  = 16'h0000;
  localparam logic [15:0] TCC_CNT_ONE   = 16'h0001;
  localparam logic [6:0]  TCC_PRE_ZERO  = 7'h00;
  localparam logic [6:0]  TCC_PRE_ONES  = 7'h7f;
  localparam logic [31:0] TCC_RD_ZERO   = 32'h0000_0000;
  localparam logic [3:0]  TCC_MODE_OFF  = 4'h0;
  localparam logic [3:0]  TCC_MODE_CMP1 = 4'h1;
  localparam logic [3:0]  TCC_MODE_CMP2 = 4'h2;
  localparam logic [3:0]  TCC_MODE_CMP3 = 4'h3;
  localparam logic [3:0]  TCC_MODE_HYST = 4'h9;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic cnt_rst;
    logic ste_clr;
    logic ste_set;
    logic run_clr;
    logic run_set;
  } tcc_cmd_t;

  typedef struct packed {
    logic       ste;
    logic       dir;
    logic       run;
    logic [2:0] state;
  } tcc_status_t;

endpackage : tcc_pkg

// file: tcc_checker_sva.sv
// concurrent checks on the ports of the timer compare channel block
`timescale 1ns/1ps
module tcc_checker
  import tcc_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               arst_n,
  input wire logic [TCC_NCH-1:0] channel_state_bit,
  input wire logic [TCC_NCH-1:0] channel_match,
  input wire logic [TCC_NCH-1:0] upcount_match_event,
  input wire logic [TCC_NCH-1:0] downcount_match_event,
  input wire logic               zero_match,
  input wire logic               one_match,
  input wire logic               shadow_transfer_pulse,
  input wire logic               timer_tick,
  input wire logic               count_direction,
  input wire logic               timer_run_bit
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  chk_up_cause: assert property (
    (upcount_match_event & ~$past(channel_match & {TCC_NCH{timer_tick && !count_direction}})) == '0)
    else $error("up event without an up-counting match tick");
  chk_down_cause: assert property (
    (downcount_match_event & ~$past(channel_match & {TCC_NCH{timer_tick && count_direction}})) == '0)
    else $error("down event without a down-counting match tick");
  chk_event_excl: assert property ((upcount_match_event & downcount_match_event) == '0)
    else $error("up and down event together");
  chk_up_sets: assert property ((upcount_match_event & ~channel_state_bit) == '0)
    else $error("state bit not set after up match");
  chk_down_clears: assert property ((downcount_match_event & channel_state_bit) == '0)
    else $error("state bit not cleared after down match");
  chk_tick_run: assert property (timer_tick |-> timer_run_bit)
    else $error("timer tick while stopped");
  chk_st_gated: assert property (shadow_transfer_pulse && timer_run_bit |-> timer_tick)
    else $error("shadow transfer off a tick while running");
  chk_zero_one: assert property (zero_match && timer_tick && !count_direction |=> one_match)
    else $error("counter did not step from zero to one");
  chk_match_src: assert property ($changed(channel_match) |-> $past(timer_tick || shadow_transfer_pulse))
    else $error("match changed without counter step or transfer");
  chk_dir_step: assert property ($changed(count_direction) |-> $past(timer_tick))
    else $error("direction changed off a tick");
endmodule : tcc_checker

bind tcc_compare_channels tcc_checker u_chk (.*);

// file: tcc_output_path.sv
// behavioural model of the dead-time and output path fed by the state bits
`timescale 1ns/1ps
module tcc_output_path
  import tcc_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               arst_n,
  input  wire logic [TCC_NCH-1:0] channel_state_bit,
  output logic      [TCC_NCH-1:0] drive_hi,
  output logic      [TCC_NCH-1:0] drive_lo
);
  logic [TCC_NCH-1:0] prev_reg;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= channel_state_bit;
    end
  end

  // a change blanks both sides for one clock so the switches never overlap
  assign drive_hi = channel_state_bit & prev_reg;
  assign drive_lo = ~channel_state_bit & ~prev_reg;
endmodule : tcc_output_path

// file: timer_compare_channel_state_test.sv
// self-checking testbench of the timer compare channel block
`timescale 1ns/1ps
module timer_compare_channel_state_test;
  import tcc_pkg::*;
  logic               ref_clk;
  logic               arst_n;
  logic [TCC_AW-1:0]  bus_addr;
  logic [TCC_DW-1:0]  bus_wdata;
  logic               bus_wr;
  logic               bus_rd;
  logic [TCC_DW-1:0]  bus_rdata;
  logic [TCC_NCH-1:0] position_input;
  logic [TCC_NCH-1:0] channel_state_bit;
  logic [TCC_NCH-1:0] channel_match;
  logic [TCC_NCH-1:0] upcount_match_event;
  logic [TCC_NCH-1:0] downcount_match_event;
  logic               zero_match;
  logic               one_match;
  logic               shadow_transfer_pulse;
  logic               timer_tick;
  logic               count_direction;
  logic               timer_run_bit;
  logic [TCC_NCH-1:0] drive_hi;
  logic [TCC_NCH-1:0] drive_lo;
  int                 err_total = 0;
  int                 check_count = 0;
  int                 cyc = 0;
  int                 hi[3];
  int                 up_n;
  int                 dn_n;
  int                 ovl;

  tcc_compare_channels dut (.*);
  tcc_output_path u_path (.*);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // gap cycle after each strobe keeps a strobe from being driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1;
    chk(n, e, bus_rdata);
    @(posedge ref_clk);
  endtask : rdchk

  task automatic count_win(input int n);
    for (int i = 0; i < 3; i++) hi[i] = 0;
    up_n = 0;
    dn_n = 0;
    ovl  = 0;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      for (int i = 0; i < 3; i++) hi[i] += int'(channel_state_bit[i] === 1'b1);
      up_n += int'(upcount_match_event[0] === 1'b1);
      dn_n += int'(downcount_match_event[0] === 1'b1);
      ovl  += int'((drive_hi & drive_lo) !== 3'h0);
    end
  endtask : count_win

  task automatic win_chk(input int h0, input int h1, input int h2, input int u, input int d);
    chk("hi_ch0", 32'(h0), 32'(hi[0]));
    chk("hi_ch1", 32'(h1), 32'(hi[1]));
    chk("hi_ch2", 32'(h2), 32'(hi[2]));
    chk("up_ev", 32'(u), 32'(up_n));
    chk("dn_ev", 32'(d), 32'(dn_n));
    chk("overlap", 32'h0, 32'(ovl));
  endtask : win_chk

  task automatic finish_test;
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_total++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    position_input = 3'h7;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    chk("zero_match", 32'h1, 32'(zero_match));
    rdchk("status", TCC_OFF_STATE, 32'h0);
    rdchk("cmp0", TCC_OFF_CMP0, 32'h0);
    rdchk("unmapped", 8'hfc, 32'h0);
    wr(TCC_OFF_PERIOD, 32'h3);
    wr(TCC_OFF_CMP0, 32'h2);
    wr(TCC_OFF_CMP0 + 8'h04, 32'h0);
    wr(TCC_OFF_CMP0 + 8'h08, 32'h4);
    wr(TCC_OFF_MODE, 32'h321);
    rdchk("shd0", TCC_OFF_SHD0, 32'h2);
    rdchk("cmp0_held", TCC_OFF_CMP0, 32'h0);
    wr(TCC_OFF_CMD, 32'h4);
    rdchk("cmp0_new", TCC_OFF_CMP0, 32'h2);
    rdchk("cmp2_new", TCC_OFF_CMP0 + 8'h08, 32'h4);
    // edge aligned, period of four ticks
    wr(TCC_OFF_CMD, 32'h1);
    count_win(8);
    count_win(40);
    win_chk(20, 40, 0, 10, 0);
    wr(TCC_OFF_CMD, 32'h2);
    count_win(10);
    win_chk(0, 10, 0, 0, 0);
    wr(TCC_OFF_MODIFY, 32'h7);
    chk("set_all", 32'h7, 32'(channel_state_bit));
    wr(TCC_OFF_MODIFY, 32'h500);
    chk("reset_some", 32'h2, 32'(channel_state_bit));
    // channel zero in hysteresis mode, channel one stays normal
    wr(TCC_OFF_MODE, 32'h329);
    wr(TCC_OFF_MODIFY, 32'h1);
    chk("hyst_set", 32'h3, 32'(channel_state_bit));
    position_input <= 3'h4;
    repeat (4) @(posedge ref_clk);
    chk("pos_low", 32'h2, 32'(channel_state_bit));
    wr(TCC_OFF_MODIFY, 32'h1);
    chk("pos_hold", 32'h2, 32'(channel_state_bit));
    position_input <= 3'h7;
    repeat (4) @(posedge ref_clk);
    wr(TCC_OFF_CMD, 32'h1);
    count_win(40);
    win_chk(20, 40, 0, 10, 0);
    wr(TCC_OFF_CMD, 32'h2);
    // edge aligned with a tick every second clock
    wr(TCC_OFF_CTRL, 32'h10);
    rdchk("ctrl", TCC_OFF_CTRL, 32'h10);
    wr(TCC_OFF_CMD, 32'h1);
    count_win(16);
    count_win(48);
    win_chk(24, 48, 0, 6, 0);
    wr(TCC_OFF_CMD, 32'h2);
    // center aligned, period of eight ticks
    wr(TCC_OFF_CTRL, 32'h1);
    wr(TCC_OFF_CMD, 32'h1);
    count_win(16);
    count_win(48);
    win_chk(24, 48, 0, 6, 6);
    wr(TCC_OFF_CMD, 32'h2);
    // channel zero switched off: it keeps a forced one and raises no events
    wr(TCC_OFF_MODE, 32'h320);
    wr(TCC_OFF_MODIFY, 32'h1);
    wr(TCC_OFF_CMD, 32'h1);
    count_win(16);
    win_chk(16, 16, 0, 0, 0);
    wr(TCC_OFF_CMD, 32'h2);
    finish_test();
  end
endmodule : timer_compare_channel_state_test
